// file: rtl/mqr_pkg.sv
/*
  Package for the multi-queue read-select block: field positions, widths,
  reset values, cycle counts and carrier structs.
  Assumes every user passes names as mqr_pkg::name, nothing imported.
*/
// Summary of operation
// - Partial reset clears only selected queue pointers
// - Word read when read and output enables low
// - Address latched on edge with select strobe
// - Flags and poll sync follow read clock
// - Six-bit address, low two bits pick queue
// - Address bit two selects the null queue
// - Upper three bits must match device id
// - Selection edge may still output old queue
// - First edge after select outputs old queue
// - Second edge after select presents new queue
// - Flag strobe latches device bits five-three
// - Almost-empty flag low for selected queue
// - Program-done low means device ready
package mqr_pkg;

  // ---------------------------------------------------------------
  // Address fields
  // ---------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int QSEL_LSB = 0;
  localparam int QSEL_W = 2;
  localparam int NULLQ_BIT = 2;
  localparam int DEV_LSB = 3;
  localparam int DEV_W = 3;
  localparam int NUM_QUEUES = 4;
  localparam int DATA_W = 18;
  localparam int DEPTH = 16;

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [QSEL_W-1:0] RST_QSEL = 2'h0;
  localparam logic [DEV_W-1:0] RST_DEV = 3'h0;
  localparam logic [DATA_W-1:0] RST_DATA = 18'h00000;
  localparam int PRS_SETUP_CYC = 2;
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] ALMOST_EMPTY_LVL = 5'h02;

  // Decoded read address
  typedef struct packed {
    logic [DEV_W-1:0] dev;
    logic null_q;
    logic [QSEL_W-1:0] queue;
  } mqr_addr_type;

  // One word on the output bus
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } mqr_word_type;

endpackage

// file: rtl/mqr_fifo.sv
/*
  Single synchronous queue with valid/ready on both sides and a pointer
  clear. Assumes one clock; clear is a one-cycle pulse.
*/
`timescale 1ns/100ps
module mqr_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_clear,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  // Level
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Extra pointer bit separates full from empty
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign push = i_in_valid && !full;
  assign pop = i_out_ready && !empty;
  assign o_out_data = mem[rd_ptr_reg[AW-1:0]];
  assign o_count = wr_ptr_reg - rd_ptr_reg;

  // Storage, no reset needed on data
  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wr_ptr_reg[AW-1:0]] <= i_in_data;
    end
  end

  // Pointers; clear returns both to the first location
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (i_ce) begin
      if (i_clear) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
      end else begin
        if (push) begin
          wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
        if (pop) begin
          rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
      end
    end
  end
endmodule

// file: rtl/mqr_top.sv
/*
  Read-port side of a four-queue flow-control buffer: queue selection,
  null queue, device match, two-stage fall-through output, flag device
  selection and single-queue partial reset. Write side is a simple
  per-queue fill port. Assumes all inputs synchronous to i_sys_clk,
  which stands for both read and write clock.
*/
`timescale 1ns/100ps
module mqr_top #(
  parameter int DATA_W = mqr_pkg::DATA_W,
  parameter int DEPTH = mqr_pkg::DEPTH,
  parameter int NQ = mqr_pkg::NUM_QUEUES,
  parameter logic [2:0] DEVICE_ID = 3'h0 // Arbitrary identity value
) (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Write fill port
  input wire logic i_wr_valid,
  input wire logic [1:0] i_wr_queue,
  input wire logic [DATA_W-1:0] i_wr_data,
  output logic o_wr_ready,
  // Read control
  input wire logic [mqr_pkg::ADDR_W-1:0] i_read_select_address,
  input wire logic i_read_queue_select_strobe,
  input wire logic i_flag_device_strobe,
  input wire logic i_read_enable_n,
  input wire logic i_output_enable_n,
  input wire logic i_partial_queue_reset_n,
  input wire logic i_program_done_in_n,
  input wire logic i_strobed_flag_mode,
  input wire logic i_expansion_token_in,
  // Read outputs
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe_n,
  output logic o_output_valid_flag_n,
  output logic o_almost_empty_flag_n,
  output logic [NQ-1:0] o_almost_empty_flag_bus,
  output logic o_almost_empty_bus_oe_n,
  output logic o_flag_poll_sync,
  output logic o_expansion_token_out,
  output logic o_program_done_out_n
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  // Two-stage release keeps deassertion clean
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Address decode shared by both strobe paths
  function automatic mqr_pkg::mqr_addr_type decode_addr(
    input logic [mqr_pkg::ADDR_W-1:0] a
  );
    decode_addr = a;
  endfunction

  mqr_pkg::mqr_addr_type addr;
  logic dev_match;
  logic ready;
  assign addr = decode_addr(i_read_select_address);
  assign dev_match = (addr.dev == DEVICE_ID);
  assign ready = !i_program_done_in_n;

  // ---------------------------------------------------------------
  // Queue selection
  // ---------------------------------------------------------------
  logic [1:0] cur_q_reg;
  logic cur_null_reg;
  logic cur_sel_reg;
  logic [1:0] pend_stage_reg;
  logic sel_edge;

  // Strobe selects only while ready; collision with flag strobe is the host's to avoid
  assign sel_edge = i_read_queue_select_strobe && ready;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q_reg <= mqr_pkg::RST_QSEL;
      cur_null_reg <= 1'b1;
      cur_sel_reg <= 1'b0;
    end else if (i_ce && sel_edge) begin
      cur_q_reg <= addr.queue;
      cur_null_reg <= addr.null_q;
      cur_sel_reg <= dev_match;
    end
  end

  // Switch delay: old queue for one more edge, new queue on the second
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_stage_reg <= 2'h0;
    end else if (i_ce) begin
      pend_stage_reg <= {pend_stage_reg[0], sel_edge};
    end
  end

  // Output queue follows selection one edge late
  logic [1:0] out_q_reg;
  logic out_active_reg;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q_reg <= mqr_pkg::RST_QSEL;
      out_active_reg <= 1'b0;
    end else if (i_ce && pend_stage_reg[0]) begin
      out_q_reg <= cur_q_reg;
      out_active_reg <= cur_sel_reg && !cur_null_reg;
    end
  end

  // ---------------------------------------------------------------
  // Queue storage
  // ---------------------------------------------------------------
  logic [NQ-1:0] q_in_ready;
  logic [NQ-1:0] q_out_valid;
  logic [NQ-1:0] q_pop;
  logic [NQ-1:0] q_clear;
  logic [NQ-1:0] q_ae;
  logic [DATA_W-1:0] q_data [NQ];
  logic [$clog2(DEPTH):0] q_count [NQ];
  logic [1:0] prs_q_reg [mqr_pkg::PRS_SETUP_CYC];
  logic load;

  // Partial reset acts on the queue held selected for two edges; the first
  // stage takes the selection as it lands so a pulse two edges later hits it
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prs_q_reg[0] <= mqr_pkg::RST_QSEL;
      prs_q_reg[1] <= mqr_pkg::RST_QSEL;
    end else if (i_ce) begin
      prs_q_reg[0] <= sel_edge ? addr.queue : cur_q_reg;
      prs_q_reg[1] <= prs_q_reg[0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NQ; g++) begin : gen_q
      assign q_clear[g] = !i_partial_queue_reset_n && (prs_q_reg[1] == 2'(g));
      assign q_pop[g] = load && (out_q_reg == 2'(g));
      assign q_ae[g] = q_count[g] <= mqr_pkg::ALMOST_EMPTY_LVL;
      mqr_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH)
      ) u_fifo (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_clear(q_clear[g]),
        .i_in_valid(i_wr_valid && ready && (i_wr_queue == 2'(g))),
        .o_in_ready(q_in_ready[g]),
        .i_in_data(i_wr_data),
        .o_out_valid(q_out_valid[g]),
        .i_out_ready(q_pop[g]),
        .o_out_data(q_data[g]),
        .o_count(q_count[g])
      );
    end
  endgenerate
  assign o_wr_ready = q_in_ready[i_wr_queue] && ready;

  // ---------------------------------------------------------------
  // Fall-through output stage
  // ---------------------------------------------------------------
  mqr_pkg::mqr_word_type out_reg;

  // Load when empty, on a read, or on the switch edge regardless of enable
  assign load = out_active_reg && q_out_valid[out_q_reg] &&
    (!out_reg.valid || (!i_read_enable_n && !i_output_enable_n) ||
     pend_stage_reg[1]);

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= '0;
    end else if (i_ce) begin
      if (load) begin
        out_reg <= {1'b1, q_data[out_q_reg]};
      end else if ((!i_read_enable_n && !i_output_enable_n) || pend_stage_reg[1] ||
                   (pend_stage_reg[0] && !(cur_sel_reg && !cur_null_reg))) begin
        out_reg.valid <= 1'b0;
      end
    end
  end
  assign o_data = out_reg.data;
  assign o_data_oe_n = i_output_enable_n || !out_active_reg;
  assign o_output_valid_flag_n = !out_reg.valid;

  // ---------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------
  logic [2:0] flag_dev_reg;
  logic [1:0] poll_q_reg;
  logic ae_reg;
  logic [NQ-1:0] ae_bus_reg;
  logic bus_oe_n_reg;
  logic sync_reg;
  logic token_reg;

  // Flag device capture; low address bits are don't care
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_dev_reg <= mqr_pkg::RST_DEV;
    end else if (i_ce && i_flag_device_strobe && i_strobed_flag_mode) begin
      flag_dev_reg <= addr.dev;
    end
  end

  // All flags registered on the read clock
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ae_reg <= 1'b1;
      ae_bus_reg <= '1;
      bus_oe_n_reg <= 1'b1;
      poll_q_reg <= 2'h0;
      sync_reg <= 1'b0;
      token_reg <= 1'b0;
    end else if (i_ce) begin
      ae_reg <= !(out_active_reg && q_ae[out_q_reg]);
      token_reg <= i_expansion_token_in;
      if (i_strobed_flag_mode) begin
        ae_bus_reg <= ~q_ae;
        bus_oe_n_reg <= (flag_dev_reg != DEVICE_ID);
        sync_reg <= 1'b0;
      end else begin
        poll_q_reg <= poll_q_reg + 2'h1;
        ae_bus_reg <= ~q_ae;
        bus_oe_n_reg <= 1'b0;
        sync_reg <= (poll_q_reg == 2'h0);
      end
    end
  end
  assign o_almost_empty_flag_n = ae_reg;
  assign o_almost_empty_flag_bus = ae_bus_reg;
  assign o_almost_empty_bus_oe_n = bus_oe_n_reg;
  assign o_flag_poll_sync = sync_reg;
  assign o_expansion_token_out = token_reg;
  assign o_program_done_out_n = i_program_done_in_n;
endmodule

// file: tb/mqr_host.sv
/*
  Host controller model: turns bench requests into read-select and
  flag-device strobes plus the read select address.
  Assumes requests change just after a rising edge.
*/
`timescale 1ns/100ps
module mqr_host (
  // Bench requests
  input wire logic i_sel_req,
  input wire logic i_flag_req,
  input wire logic i_done_n,
  input wire logic [5:0] i_addr,
  // Read control pins
  output logic o_sel_strobe,
  output logic o_flag_strobe,
  output logic [5:0] o_addr
);
  // Select only once configured, one change cycle per request
  assign o_sel_strobe = i_sel_req & ~i_done_n;
  // Selection wins a clash, so the two strobes never meet
  assign o_flag_strobe = i_flag_req & ~i_sel_req;
  assign o_addr = i_addr;
endmodule

// file: tb/mqr_chk.sv
/*
  Port assertions for mqr_top: selection, flags, pass-through pins.
  Assumes i_ce held high and binding from the bench top.
*/
`timescale 1ns/100ps
module mqr_chk #(
  parameter logic [2:0] DEVICE_ID = 3'h0
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [5:0] i_read_select_address,
  input wire logic i_read_queue_select_strobe,
  input wire logic i_flag_device_strobe,
  input wire logic i_output_enable_n,
  input wire logic i_program_done_in_n,
  input wire logic i_strobed_flag_mode,
  input wire logic i_expansion_token_in,
  input wire logic o_data_oe_n,
  input wire logic o_almost_empty_bus_oe_n,
  input wire logic o_flag_poll_sync,
  input wire logic o_expansion_token_out,
  input wire logic o_program_done_out_n
);
  // -------------------------------------------------------------
  // Arming
  // -------------------------------------------------------------
  // Internal reset lags the pin by two edges, so wait that out
  logic [2:0] up_reg;
  logic arm;
  logic [2:0] dev;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up_reg <= 3'h0;
    end else if (up_reg != 3'h4) begin
      up_reg <= up_reg + 3'h1;
    end
  end
  assign arm = (up_reg == 3'h4);
  assign dev = i_read_select_address[5:3];
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  AST_TOKEN:
    assert property (arm && i_ce |=> o_expansion_token_out == $past(i_expansion_token_in))
    else $error("token out not one cycle behind");
  AST_DONE:
    assert property (o_program_done_out_n == i_program_done_in_n)
    else $error("program done out not following");
  AST_OE:
    assert property (i_output_enable_n |-> o_data_oe_n)
    else $error("data driven with output enable off");
  AST_NULL:
    assert property (arm && i_read_queue_select_strobe && i_read_select_address[2]
      && !i_program_done_in_n ##1 !i_read_queue_select_strobe |=> o_data_oe_n)
    else $error("null queue drives data");
  AST_DEV:
    assert property (arm && i_read_queue_select_strobe && dev != DEVICE_ID
      && !i_program_done_in_n ##1 !i_read_queue_select_strobe |=> o_data_oe_n)
    else $error("other device drives data");
  AST_SYNC:
    assert property (arm && o_flag_poll_sync && !i_strobed_flag_mode
      |=> !o_flag_poll_sync [*3] ##1 (o_flag_poll_sync || i_strobed_flag_mode))
    else $error("poll sync period wrong");
  AST_BUSOE:
    assert property (arm && !i_strobed_flag_mode ##1 !i_strobed_flag_mode
      |-> !o_almost_empty_bus_oe_n)
    else $error("polled flag bus not driven");
  AST_FLAGDEV:
    assert property (arm && i_strobed_flag_mode && i_flag_device_strobe
      ##1 (i_strobed_flag_mode && !i_flag_device_strobe)
      |=> o_almost_empty_bus_oe_n == ($past(dev, 2) != DEVICE_ID))
    else $error("flag bus device match wrong");
endmodule

// file: tb/tb.sv
/*
  Bench for mqr_top: fills queues, selects, reads, resets one queue,
  exercises null and foreign addresses and the flag bus.
  Assumes the host model and checker files compile first.
*/
`timescale 1ns/100ps
module tb;
  logic i_sys_clk, i_rst_n, i_wr_valid, i_read_enable_n, i_output_enable_n;
  logic i_partial_queue_reset_n, i_program_done_in_n, i_strobed_flag_mode;
  logic i_expansion_token_in, sel_req, flag_req;
  logic i_read_queue_select_strobe, i_flag_device_strobe;
  logic [1:0] i_wr_queue;
  logic [17:0] i_wr_data, o_data;
  logic [5:0] h_addr, i_read_select_address;
  logic o_wr_ready, o_data_oe_n, o_output_valid_flag_n, o_almost_empty_flag_n;
  logic o_almost_empty_bus_oe_n, o_flag_poll_sync, o_expansion_token_out;
  logic o_program_done_out_n;
  logic [3:0] o_almost_empty_flag_bus;
  int num_errors = 0;
  int total_checks = 0;

  mqr_top uut (.i_ce(1'b1), .i_sys_clk, .i_rst_n, .i_wr_valid, .i_wr_queue,
    .i_wr_data, .o_wr_ready, .i_read_select_address, .i_read_queue_select_strobe,
    .i_flag_device_strobe, .i_read_enable_n, .i_output_enable_n,
    .i_partial_queue_reset_n, .i_program_done_in_n, .i_strobed_flag_mode,
    .i_expansion_token_in, .o_data, .o_data_oe_n, .o_output_valid_flag_n,
    .o_almost_empty_flag_n, .o_almost_empty_flag_bus, .o_almost_empty_bus_oe_n,
    .o_flag_poll_sync, .o_expansion_token_out, .o_program_done_out_n);
  mqr_host host (.i_sel_req(sel_req), .i_flag_req(flag_req),
    .i_done_n(i_program_done_in_n), .i_addr(h_addr),
    .o_sel_strobe(i_read_queue_select_strobe),
    .o_flag_strobe(i_flag_device_strobe), .o_addr(i_read_select_address));

  // Free-running clock, never gated
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [17:0] e, input logic [17:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // Back-to-back writes, valid held high across the burst; one idle edge
  // after it so a following burst never re-raises valid in the same step
  task automatic wr_burst(input logic [1:0] q, input logic [17:0] b, input int n);
    i_wr_queue = q;
    i_wr_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      i_wr_data = b + 18'(i);
      chk_bit("wr_ready", 1'b1, o_wr_ready);
      cyc(1);
    end
    i_wr_valid = 1'b0;
    cyc(1);
  endtask
  // Strobe taken at the next edge, then two edges for fall-through
  task automatic pick(input logic [5:0] a);
    sel_req = 1'b1;
    h_addr = a;
    cyc(1);
    sel_req = 1'b0;
    cyc(2);
  endtask
  task automatic flag_pick(input logic [5:0] a);
    flag_req = 1'b1;
    h_addr = a;
    cyc(1);
    flag_req = 1'b0;
    cyc(2);
  endtask

  task automatic s_select_read();
    wr_burst(2'h1, 18'h00010, 6);
    wr_burst(2'h2, 18'h00020, 4);
    pick(6'h01);
    chk_word("q1 head", 18'h00010, o_data);
    chk_bit("valid_n", 1'b0, o_output_valid_flag_n);
    for (int i = 1; i < 3; i++) begin
      i_read_enable_n = 1'b0;
      cyc(1);
      i_read_enable_n = 1'b1;
      cyc(2);
      chk_word("q1 next", 18'h00010 + 18'(i), o_data);
    end
    sel_req = 1'b1;
    h_addr = 6'h02;
    cyc(1);
    sel_req = 1'b0;
    cyc(1);
    chk_word("old queue word", 18'h00012, o_data);
    cyc(1);
    chk_word("q2 head", 18'h00020, o_data);
    chk_bit("ae q2 full", 1'b1, o_almost_empty_flag_n);
  endtask
  // Queue two is selected on both ports well before the pulse
  task automatic s_partial_reset();
    i_partial_queue_reset_n = 1'b0;
    cyc(1);
    i_partial_queue_reset_n = 1'b1;
    cyc(2);
    chk_bit("ae q2 cleared", 1'b0, o_almost_empty_flag_n);
    pick(6'h01);
    chk_bit("ae q1 kept", 1'b1, o_almost_empty_flag_n);
    i_program_done_in_n = 1'b1;
    #1;
    chk_bit("wr_ready unconfigured", 1'b0, o_wr_ready);
    chk_bit("done out", 1'b1, o_program_done_out_n);
    i_program_done_in_n = 1'b0;
    cyc(1);
  endtask
  task automatic s_null_dev();
    pick(6'h04);
    chk_bit("null oe_n", 1'b1, o_data_oe_n);
    chk_bit("null valid_n", 1'b1, o_output_valid_flag_n);
    pick(6'h09);
    chk_bit("foreign oe_n", 1'b1, o_data_oe_n);
    pick(6'h01);
    chk_bit("own oe_n", 1'b0, o_data_oe_n);
    i_output_enable_n = 1'b1;
    i_read_enable_n = 1'b0;
    cyc(1);
    chk_bit("oe off oe_n", 1'b1, o_data_oe_n);
    chk_word("no read with oe off", 18'h00014, o_data);
    i_output_enable_n = 1'b0;
    i_read_enable_n = 1'b1;
  endtask
  task automatic s_flags();
    wr_burst(2'h3, 18'h00030, 3);
    i_expansion_token_in = 1'b1;
    cyc(1);
    chk_bit("token", 1'b1, o_expansion_token_out);
    chk_word("polled flag bus", 18'h00008, 18'(o_almost_empty_flag_bus));
    chk_bit("polled bus oe_n", 1'b0, o_almost_empty_bus_oe_n);
    i_expansion_token_in = 1'b0;
    i_strobed_flag_mode = 1'b1;
    flag_pick(6'h28);
    chk_bit("other dev bus oe_n", 1'b1, o_almost_empty_bus_oe_n);
    flag_pick(6'h07);
    chk_bit("own dev bus oe_n", 1'b0, o_almost_empty_bus_oe_n);
  endtask

  task automatic close_out();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole sequence needs about 72 cycles
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    num_errors++;
    close_out();
  end

  initial begin
    {i_rst_n, i_wr_valid, i_output_enable_n, i_strobed_flag_mode} = 4'h0;
    {i_expansion_token_in, sel_req, flag_req, i_program_done_in_n} = 4'h0;
    {i_read_enable_n, i_partial_queue_reset_n} = 2'h3;
    i_wr_queue = 2'h0;
    i_wr_data = 18'h00000;
    h_addr = 6'h00;
    cyc(16);
    i_rst_n = 1'b1;
    cyc(4);
    s_select_read();
    s_partial_reset();
    s_null_dev();
    s_flags();
    close_out();
  end
endmodule

bind mqr_top mqr_chk #(.DEVICE_ID(DEVICE_ID)) chk (.i_sys_clk, .i_rst_n, .i_ce,
  .i_read_select_address, .i_read_queue_select_strobe, .i_flag_device_strobe,
  .i_output_enable_n, .i_program_done_in_n, .i_strobed_flag_mode,
  .i_expansion_token_in, .o_data_oe_n, .o_almost_empty_bus_oe_n, .o_flag_poll_sync,
  .o_expansion_token_out, .o_program_done_out_n);
